// >>> aspm_majority.sv
// Purpose: Two-of-three bit detector at counter states 7, 8 and 9.
// Assumes: phase is the receive divide-by-16 count, tick its advance pulse.
// Notes:   bit_valid pulses on the tick of state 9.
`timescale 1ns/100ps
module aspm_majority
    import aspm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       tick,
    input  wire logic [3:0] phase,
    input  wire logic       line,
    output logic            bit_valid,
    output logic            bit_value
);
    logic s7_ff;
    logic s8_ff;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s7_ff <= 1'b1;
            s8_ff <= 1'b1;
        end
        else if (tick)
        begin
            if (phase == SAMPLE_FIRST)
                s7_ff <= line;
            if (phase == SAMPLE_MID)
                s8_ff <= line;
        end
    end

    assign bit_valid = tick && (phase == SAMPLE_LAST);
    assign bit_value = maj3(s7_ff, s8_ff, line);
endmodule

// >>> aspm_pkg.sv
// Purpose: Shared constants, register layout and carrier types of the async serial port.
// Assumes: 8-bit register bus with a 4-bit word address.
// Notes:   Modes 1, 2 and 3 only; mode 0 leaves the port idle.
package aspm_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFS_SERIAL_CONTROL = 4'h0;
    localparam logic [3:0] OFS_SERIAL_BUFFER  = 4'h1;
    localparam logic [3:0] OFS_RATE_CONFIG    = 4'h2;
    localparam logic [3:0] OFS_PORT_STATUS    = 4'h3;

    // Mode encodings in serial_control
    localparam logic [1:0] MODE_SHIFT   = 2'h0;
    localparam logic [1:0] MODE_TEN     = 2'h1;
    localparam logic [1:0] MODE_FIXED11 = 2'h2;
    localparam logic [1:0] MODE_VAR11   = 2'h3;

    // Field positions of serial_control
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_MPE_BIT  = 5;
    localparam int CTRL_REN_BIT  = 4;
    localparam int CTRL_TB8_BIT  = 3;
    localparam int CTRL_RB8_BIT  = 2;
    localparam int CTRL_TI_BIT   = 1;
    localparam int CTRL_RI_BIT   = 0;

    // Field positions of rate_config
    localparam int RATE_HALF_BIT  = 0;
    localparam int RATE_SIX_BIT   = 1;
    localparam int RATE_TIMER_BIT = 2;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET  = 8'h00;

    // Bit timing
    localparam logic [3:0] DIV16_LAST   = 4'hf;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_MID   = 4'h8;
    localparam logic [3:0] SAMPLE_LAST  = 4'h9;
    localparam logic [8:0] RSR_LOAD     = 9'h1ff;
    localparam int FIXED_DIV_TWELVE_FAST = 32;
    localparam int FIXED_DIV_TWELVE_SLOW = 64;
    localparam int FIXED_DIV_SIX_FAST    = 16;
    localparam int FIXED_DIV_SIX_SLOW    = 32;
    localparam int OVERSAMPLE            = 16;

    typedef struct packed {
        logic [1:0] mode;
        logic       multiprocessor_enable;
        logic       receive_enable;
        logic       transmit_ninth_bit;
        logic       received_ninth_bit;
        logic       transmit_done_flag;
        logic       receive_done_flag;
    } aspm_ctrl_t;

    typedef struct packed {
        logic [4:0] unused;
        logic       timer_select;
        logic       six_clock_core;
        logic       half_rate;
    } aspm_rate_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } aspm_bus_req_t;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

endpackage

// >>> aspm_props.sv
// Purpose: Port-level checks of the async serial port.
// Assumes: Bound to aspm_top; one clock domain.
// Notes:   Mode shadow is software owned, so hardware never moves it.
`timescale 1ns/100ps
module aspm_props
    import aspm_pkg::*;
(
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic              bus_wr,
    input wire logic              bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic              rxd,
    input wire logic              txd
);
    logic [1:0] mode_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            mode_ff <= 2'h0;
        else if (bus_wr && bus_addr == OFS_SERIAL_CONTROL)
            mode_ff <= bus_wdata[7:6];

    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_unmapped_read: assert property (bus_rd && bus_addr > OFS_PORT_STATUS |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_rxd: assert property (bus_rd && bus_addr == OFS_PORT_STATUS |=>
        bus_rdata[0] == $past(rxd) && bus_rdata[7:3] == 5'h00)
        else $error("status read wrong");
    a_rate_readback: assert property (bus_wr && bus_addr == OFS_RATE_CONFIG ##1
        bus_rd && bus_addr == OFS_RATE_CONFIG |=> bus_rdata == ($past(bus_wdata, 2) & 8'h07))
        else $error("rate readback wrong");
    a_ctrl_readback: assert property (bus_wr && bus_addr == OFS_SERIAL_CONTROL ##1
        bus_rd && bus_addr == OFS_SERIAL_CONTROL |=>
        (bus_rdata & 8'hf8) == ($past(bus_wdata, 2) & 8'hf8))
        else $error("control readback wrong");
    // Fastest tick is one clock, so no bit is shorter than 16 clocks
    a_tx_low_hold: assert property ($fell(txd) |-> !txd [*8])
        else $error("txd low shorter than a bit");
    a_tx_high_hold: assert property ($rose(txd) |-> txd [*8])
        else $error("txd high shorter than a bit");
    a_off_idle: assert property (mode_ff == MODE_SHIFT |-> txd)
        else $error("txd active with port off");
endmodule

bind aspm_top aspm_props aspm_props_i (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .rxd(rxd), .txd(txd));

// >>> aspm_remote.sv
// Purpose: Remote serial node facing the port's txd and rxd.
// Assumes: Bit time given in clocks by the caller.
// Notes:   Samples at mid-bit on falling clock edges to stay clear of updates.
`timescale 1ns/100ps
module aspm_remote
(
    input  wire logic clock,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    task automatic send(input logic [10:0] frame, input int n, input int cpb);
        for (int i = 0; i < n; i++)
        begin
            rxd <= frame[i];
            repeat (cpb) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask

    // Deliberate short low pulse, then idle long enough to re-arm
    task automatic glitch(input int k);
        rxd <= 1'b0;
        repeat (k) @(posedge clock);
        rxd <= 1'b1;
        repeat (40) @(posedge clock);
    endtask

    task automatic recv(input int n, input int cpb, input int lim,
                        output logic [10:0] frame, output logic seen);
        int i;
        frame = '0;
        seen = 1'b0;
        for (i = 0; i < lim && txd; i++)
            @(negedge clock);
        if (!txd)
        begin
            seen = 1'b1;
            repeat (cpb / 2) @(negedge clock);
            for (i = 0; i < n; i++)
            begin
                frame[i] = txd;
                repeat (cpb) @(negedge clock);
            end
        end
    endtask
endmodule

// >>> aspm_test.sv
// Purpose: Self-checking bench of the async serial port.
// Assumes: Timer overflows pulse every second clock, so 32 clocks a bit.
// Notes:   Fixed-rate receive uses 16 clocks a bit, fixed-rate transmit 64.
`timescale 1ns/100ps
module aspm_test;
    import aspm_pkg::*;
    logic              clock = 1'b0;
    logic              sys_rst = 1'b1;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic              bus_wr = 1'b0;
    logic              bus_rd = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    logic              rxd;
    logic              txd;
    logic              timer_a_ovf = 1'b0;
    logic              timer_b_ovf = 1'b0;
    int                num_errors = 0;
    int                n_checks = 0;
    logic [1:0]        md [5] = '{MODE_TEN, MODE_TEN, MODE_FIXED11, MODE_VAR11, MODE_VAR11};
    logic [7:0]        rt [5] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h04};
    logic [7:0]        dat [5] = '{8'h5a, 8'hc3, 8'h81, 8'h7e, 8'h18};
    logic              nin [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic              mpe [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic              clr [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic              acc [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    always #25 clock = ~clock;
    always @(posedge clock) timer_a_ovf <= ~timer_a_ovf;
    always @(posedge clock) timer_b_ovf <= ~timer_b_ovf;

    aspm_top aspm_top_i (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .rxd(rxd), .txd(txd), .timer_a_ovf(timer_a_ovf), .timer_b_ovf(timer_b_ovf));
    aspm_remote aspm_remote_i (.clock(clock), .txd(txd), .rxd(rxd));

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The trailing step keeps two strobe edits out of one time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic wait_ctrl(input int b, output logic [7:0] d);
        for (int i = 0; i < 400; i++)
        begin
            rd(OFS_SERIAL_CONTROL, d);
            if (d[b] === 1'b1)
                return;
        end
        num_errors++;
        $display("ERROR flag %0d expected 1 seen 0", b);
        print_verdict();
    endtask

    initial
    begin
        logic [7:0]  d;
        logic [10:0] f;
        logic        seen;
        logic [7:0]  eb;
        logic        e8;
        int          n;
        int          cpb;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (rt[k])
        begin
            rd(4'(k == 4 ? 15 : k), d);
            check("reset read", (k == 3) ? 11'h001 : 11'h000, 11'(d));
        end
        wr(OFS_RATE_CONFIG, 8'hff);
        rd(OFS_RATE_CONFIG, d);
        check("rate", 11'h007, 11'(d));
        wr(OFS_SERIAL_CONTROL, 8'h38);
        rd(OFS_SERIAL_CONTROL, d);
        check("control", 11'h038, 11'(d));
        wr(OFS_SERIAL_BUFFER, 8'h55);
        rd(OFS_PORT_STATUS, d);
        check("status off", 11'h001, 11'(d));
        // Transmit in all three modes, second write dropped while busy
        for (int k = 1; k < 5; k++)
        begin
            cpb = (k == 2) ? 64 : 32;
            n = (md[k] == MODE_TEN) ? 10 : 11;
            wr(OFS_RATE_CONFIG, (k == 2) ? 8'h01 : rt[k]);
            wr(OFS_SERIAL_CONTROL, {md[k], 2'h0, nin[k], 3'h0});
            wr(OFS_SERIAL_BUFFER, dat[k]);
            wr(OFS_SERIAL_BUFFER, 8'hff);
            rd(OFS_PORT_STATUS, d);
            check("status busy", 11'h003, 11'(d));
            aspm_remote_i.recv(n, cpb, 2000, f, seen);
            check("tx frame", (md[k] == MODE_TEN) ? {2'b01, dat[k], 1'b0} :
                  {1'b1, nin[k], dat[k], 1'b0}, f);
            wait_ctrl(CTRL_TI_BIT, d);
            aspm_remote_i.recv(1, cpb, 200, f, seen);
            check("extra frame", 11'h000, 11'(seen));
        end
        rd(OFS_PORT_STATUS, d);
        check("status idle", 11'h001, 11'(d));
        // Receive: accept, lost with flag set, accept after a glitch, filtered, accepted address
        eb = 8'h00;
        e8 = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            cpb = (rt[k] == 8'h02) ? 16 : 32;
            n = (md[k] == MODE_TEN) ? 10 : 11;
            if (clr[k])
            begin
                wr(OFS_RATE_CONFIG, rt[k]);
                wr(OFS_SERIAL_CONTROL, {md[k], mpe[k], 1'b1, 4'h0});
            end
            if (k == 2)
                aspm_remote_i.glitch(8);
            aspm_remote_i.send({1'b1, nin[k], dat[k], 1'b0}, n, cpb);
            if (acc[k])
            begin
                eb = dat[k];
                e8 = nin[k];
            end
            rd(OFS_SERIAL_CONTROL, d);
            check("rx done", 11'(acc[k] | !clr[k]), 11'(d[0]));
            check("rx ninth", 11'(e8), 11'(d[2]));
            rd(OFS_SERIAL_BUFFER, d);
            check("rx buffer", 11'(eb), 11'(d));
        end
        print_verdict();
    end
endmodule

// >>> aspm_tick_gen.sv
// Purpose: 16x oversampling tick from oscillator division or a timer overflow.
// Assumes: clock is the oscillator; timer overflows are one-cycle pulses.
// Notes:   Tick is registered; a one-cycle pulse, but held high every clock when the fixed-rate period is one clock.
`timescale 1ns/100ps
module aspm_tick_gen
    import aspm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [1:0] mode,
    input  aspm_pkg::aspm_rate_t rate,
    input  wire logic       timer_a_ovf,
    input  wire logic       timer_b_ovf,
    output logic            tick
);
    localparam int DIV_W = 3;

    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] period;
    logic             tick_ff;
    logic             nxt_tick;

    // Clocks per oversample tick = bit division / 16
    always_comb
    begin
        if (rate.six_clock_core)
            period = rate.half_rate ? DIV_W'(FIXED_DIV_SIX_SLOW / OVERSAMPLE)
                                    : DIV_W'(FIXED_DIV_SIX_FAST / OVERSAMPLE);
        else
            period = rate.half_rate ? DIV_W'(FIXED_DIV_TWELVE_SLOW / OVERSAMPLE)
                                    : DIV_W'(FIXED_DIV_TWELVE_FAST / OVERSAMPLE);
    end

    always_comb
    begin
        case (mode)
            MODE_FIXED11: nxt_tick = (div_ff == period - DIV_W'(1));
            MODE_TEN,
            MODE_VAR11:   nxt_tick = rate.timer_select ? timer_b_ovf : timer_a_ovf;
            default:      nxt_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            div_ff <= '0;
        else if (mode != MODE_FIXED11 || div_ff == period - DIV_W'(1))
            div_ff <= '0;
        else
            div_ff <= div_ff + DIV_W'(1);
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            tick_ff <= 1'b0;
        else
            tick_ff <= nxt_tick;
    end

    assign tick = tick_ff;
endmodule

// >>> aspm_top.sv
// Purpose: Async serial port, 10-bit mode and both 11-bit modes.
// Assumes: rxd and timer overflows are synchronous to clock (20 MHz oscillator).
// Notes:   Register bus: read data valid only in the cycle after the read strobe.
`timescale 1ns/100ps
module aspm_top
    import aspm_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic [ADDR_W-1:0]     bus_addr,
    input  wire logic [DATA_W-1:0]     bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic      [DATA_W-1:0]     bus_rdata,
    input  wire logic                  rxd,
    output logic                       txd,
    input  wire logic                  timer_a_ovf,
    input  wire logic                  timer_b_ovf
);
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT,
        TX_START,
        TX_FIRST,
        TX_SHIFT
    } aspm_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_BITS,
        RX_TAIL
    } aspm_rx_state_t;

    aspm_bus_req_t  req;
    aspm_ctrl_t     ctrl_ff;
    aspm_ctrl_t     nxt_ctrl;
    aspm_rate_t     rate_ff;
    aspm_tx_state_t tx_state_ff;
    aspm_tx_state_t nxt_tx_state;
    aspm_rx_state_t rx_state_ff;
    aspm_rx_state_t nxt_rx_state;

    logic [7:0] rx_buf_ff;
    logic [8:0] tsr_ff;
    logic [8:0] rsr_ff;
    logic [3:0] tx_cnt_ff;
    logic [3:0] rx_cnt_ff;
    logic       txd_ff;
    logic       rxd_last_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic       tick;
    logic       tx_roll;
    logic       bit_valid;
    logic       bit_value;
    logic       eleven;
    logic       port_on;
    logic       buf_write;
    logic       tx_last;
    logic       tx_done;
    logic       rx_edge;
    logic       rx_final;
    logic       rx_accept;

    assign req.addr  = bus_addr;
    assign req.wdata = bus_wdata;
    assign req.wr    = bus_wr;
    assign req.rd    = bus_rd;

    assign eleven    = ctrl_ff.mode[1];
    assign port_on   = ctrl_ff.mode != MODE_SHIFT;
    assign buf_write = req.wr && req.addr == OFS_SERIAL_BUFFER;

    aspm_tick_gen u_tick
    (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .mode        (ctrl_ff.mode),
        .rate        (rate_ff),
        .timer_a_ovf (timer_a_ovf),
        .timer_b_ovf (timer_b_ovf),
        .tick        (tick)
    );

    aspm_majority u_maj
    (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .tick      (tick),
        .phase     (rx_cnt_ff),
        .line      (rxd),
        .bit_valid (bit_valid),
        .bit_value (bit_value)
    );

    // Transmit side

    // Free-running bit clock; rollovers pace every transmit bit
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            tx_cnt_ff <= '0;
        else if (tick)
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
    end

    assign tx_roll = tick && tx_cnt_ff == DIV16_LAST;

    // Marker one just left of the bit being output, only zeros above it
    assign tx_last = tsr_ff[8:2] == 7'h00 && tsr_ff[1];
    assign tx_done = tx_state_ff == TX_SHIFT && tx_roll && tx_last;

    always_comb
    begin
        nxt_tx_state = tx_state_ff;
        case (tx_state_ff)
            TX_IDLE:
                if (buf_write && port_on)
                    nxt_tx_state = TX_WAIT;
            TX_WAIT:
                if (tx_roll)
                    nxt_tx_state = TX_START;
            TX_START:
                if (tx_roll)
                    nxt_tx_state = TX_FIRST;
            TX_FIRST:
                if (tx_roll)
                    nxt_tx_state = TX_SHIFT;
            TX_SHIFT:
                if (tx_done)
                    nxt_tx_state = TX_IDLE;
            default:
                nxt_tx_state = TX_IDLE;
        endcase
        if (!port_on)
            nxt_tx_state = TX_IDLE;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            tx_state_ff <= TX_IDLE;
        else
            tx_state_ff <= nxt_tx_state;
    end

    // Writes during a frame are dropped so the frame on the line stays whole
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            tsr_ff <= '0;
        else if (tx_state_ff == TX_IDLE && buf_write)
        begin
            if (eleven)
                tsr_ff <= {ctrl_ff.transmit_ninth_bit, req.wdata};
            else
                tsr_ff <= {1'b1, req.wdata};
        end
        else if (tx_roll && tx_state_ff == TX_FIRST)
            tsr_ff <= {eleven, tsr_ff[8:1]};
        else if (tx_roll && tx_state_ff == TX_SHIFT)
            tsr_ff <= {1'b0, tsr_ff[8:1]};
    end

    // Line: idle high, start low, then shifter output; LSB leaves first
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            txd_ff <= 1'b1;
        else if (nxt_tx_state == TX_START)
            txd_ff <= 1'b0;
        else if (nxt_tx_state == TX_FIRST || nxt_tx_state == TX_SHIFT)
            txd_ff <= tx_roll ? ((tx_state_ff == TX_START) ? tsr_ff[0] : tsr_ff[1])
                              : tsr_ff[0];
        else
            txd_ff <= 1'b1;
    end

    // Receive side

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rxd_last_ff <= 1'b1;
        else if (tick)
            rxd_last_ff <= rxd;
    end

    // Edge search only at the 16x sample instants
    assign rx_edge = rx_state_ff == RX_IDLE && tick && rxd_last_ff && !rxd
                     && ctrl_ff.receive_enable && port_on;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rx_cnt_ff <= '0;
        else if (rx_edge)
            rx_cnt_ff <= '0;
        else if (tick)
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end

    // Start bit has reached the far end of the input shifter
    assign rx_final  = rx_state_ff == RX_BITS && bit_valid && !rsr_ff[0];
    assign rx_accept = rx_final && !ctrl_ff.receive_done_flag
                       && (!ctrl_ff.multiprocessor_enable || bit_value);

    always_comb
    begin
        nxt_rx_state = rx_state_ff;
        case (rx_state_ff)
            RX_IDLE:
                if (rx_edge)
                    nxt_rx_state = RX_BITS;
            RX_BITS:
                if (bit_valid)
                begin
                    if (rsr_ff == RSR_LOAD && bit_value)
                        nxt_rx_state = RX_IDLE;
                    else if (rx_final)
                        nxt_rx_state = eleven ? RX_TAIL : RX_IDLE;
                end
            RX_TAIL:
                if (bit_valid)
                    nxt_rx_state = RX_IDLE;
            default:
                nxt_rx_state = RX_IDLE;
        endcase
        if (!port_on || !ctrl_ff.receive_enable)
            nxt_rx_state = RX_IDLE;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rx_state_ff <= RX_IDLE;
        else
            rx_state_ff <= nxt_rx_state;
    end

    // Bits enter at the top; the loaded ones drain out at the bottom
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rsr_ff <= RSR_LOAD;
        else if (rx_edge)
            rsr_ff <= RSR_LOAD;
        else if (rx_state_ff == RX_BITS && bit_valid)
            rsr_ff <= {bit_value, rsr_ff[8:1]};
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rx_buf_ff <= BUF_RESET;
        else if (rx_accept)
            rx_buf_ff <= rsr_ff[8:1];
    end

    // Registers

    // Hardware sets beat a software clear in the same cycle
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (req.wr && req.addr == OFS_SERIAL_CONTROL)
            nxt_ctrl = aspm_ctrl_t'(req.wdata);
        if (tx_done)
            nxt_ctrl.transmit_done_flag = 1'b1;
        if (rx_accept)
        begin
            nxt_ctrl.receive_done_flag  = 1'b1;
            nxt_ctrl.received_ninth_bit = bit_value;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_ff <= aspm_ctrl_t'(CTRL_RESET);
        else
            ctrl_ff <= nxt_ctrl;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rate_ff <= aspm_rate_t'(RATE_RESET);
        else if (req.wr && req.addr == OFS_RATE_CONFIG)
            rate_ff <= aspm_rate_t'({5'h00, req.wdata[2:0]});
    end

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (req.rd)
        begin
            case (req.addr)
                OFS_SERIAL_CONTROL: nxt_rdata = ctrl_ff;
                OFS_SERIAL_BUFFER:  nxt_rdata = rx_buf_ff;
                OFS_RATE_CONFIG:    nxt_rdata = rate_ff;
                OFS_PORT_STATUS:    nxt_rdata = {5'h00, rx_state_ff != RX_IDLE,
                                                 tx_state_ff != TX_IDLE, rxd};
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data stand for exactly one cycle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    assign bus_rdata = rdata_ff;
    assign txd       = txd_ff;
endmodule
